// >>> rtl/ets_pkg.sv
// Shared constants and types of the event trigger scheduler.
// Assumes every file that uses it imports the whole package.
package ets_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int ETS_NUM_EVENTS = 8;
   localparam int ETS_NUM_TRIG = 8;
   localparam int ETS_NUM_FIFO = 4;
   localparam int ETS_DEEP_FIFOS = 2;
   localparam int ETS_DEEP_DEPTH = 16;
   localparam int ETS_SHALLOW_DEPTH = 4;
   localparam int ETS_MAX_CMDS = 24;
   localparam int ETS_CMD_IDX_W = 5;
   localparam int ETS_CNT_W = 16;
   localparam int ETS_CHAN_W = 5;
   localparam int ETS_RES_W = 12;
   localparam int ETS_NUM_PULSE = 4;
   localparam int ETS_NUM_ADC = 2;

   // ------------------------------------------------------------
   // Edge selection codes
   // ------------------------------------------------------------
   localparam logic [1:0] ETS_EDGE_RISE = 2'h1;
   localparam logic [1:0] ETS_EDGE_FALL = 2'h2;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ETS_ST_IDLE = 2'h0,
      ETS_ST_SEND = 2'h1,
      ETS_ST_WAIT = 2'h3
   } ets_state_t;

   // One converter command
   typedef struct packed {
      logic [1:0] fifo_sel;
      logic dual;
      logic adc_sel;
      logic [ETS_CHAN_W-1:0] chan;
   } ets_cmd_t;

   // Per-trigger setup
   typedef struct packed {
      logic [ETS_CNT_W-1:0] delay;
      logic [ETS_CMD_IDX_W-1:0] first_cmd;
      logic [ETS_CMD_IDX_W-1:0] num_cmd;
      logic [ETS_NUM_PULSE-1:0] pulse_mask;
   } ets_trig_cfg_t;

   // One stored conversion result
   typedef struct packed {
      logic adc_id;
      logic [ETS_CHAN_W-1:0] chan;
      logic [ETS_RES_W-1:0] data;
   } ets_result_t;
endpackage

// >>> rtl/ets_edge_detect.sv
// Event input synchroniser and per-input edge selection.
// Assumes raw events are asynchronous to clock_in.
`timescale 1ns/1ps
`default_nettype none
module ets_edge_detect
   import ets_pkg::*;
#(
   parameter int N = ETS_NUM_EVENTS
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [N-1:0] event_in,
   input wire logic [N-1:0][1:0] edge_sel_in,
   output logic [N-1:0] hit_out
);
   logic [N-1:0] sync1_reg;
   logic [N-1:0] sync2_reg;
   logic [N-1:0] prev_reg;

   // Two-stage synchroniser, then one history stage
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= event_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // Edge qualification per input
   genvar g;
   for (g = 0; g < N; g++) begin : g_edge
      always_ff @(posedge clock_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            hit_out[g] <= 1'b0;
         end else begin
            hit_out[g] <= ((edge_sel_in[g] & ETS_EDGE_RISE) != 2'h0 && sync2_reg[g] && !prev_reg[g])
               || ((edge_sel_in[g] & ETS_EDGE_FALL) != 2'h0 && !sync2_reg[g] && prev_reg[g]);
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ets_result_fifo.sv
// Result FIFO with registered read data and registered flags.
// Assumes the reader pops only while not empty.
`timescale 1ns/1ps
`default_nettype none
module ets_result_fifo
   import ets_pkg::*;
#(
   parameter int WIDTH = $bits(ets_result_t),
   parameter int DEPTH = ETS_DEEP_DEPTH
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic wr_valid_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic wr_ready_out,
   input wire logic rd_in,
   output logic [WIDTH-1:0] rd_data_out,
   output logic rd_valid_out,
   output logic empty_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic do_wr;
   logic do_rd;

   assign do_wr = wr_valid_in && wr_ready_out;
   assign do_rd = rd_in && !empty_out;

   // Occupancy after this cycle
   always_comb begin
      count_next = count_reg;
      if (do_wr && !do_rd) begin
         count_next = count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Storage array
   always_ff @(posedge clock_in) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= wr_data_in;
      end
   end

   // Pointers, flags and read data
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         empty_out <= 1'b1;
         wr_ready_out <= 1'b1;
         rd_valid_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            rd_data_out <= mem[rd_ptr_reg];
         end
         rd_valid_out <= do_rd;
         count_reg <= count_next;
         empty_out <= (count_next == '0);
         wr_ready_out <= (count_next != (AW+1)'(DEPTH));
      end
   end
endmodule
`default_nettype wire

// >>> rtl/ets_scheduler.sv
// Event trigger scheduler: counter, comparators, command sequencer, FIFOs.
// Assumes converters and timers run on clock_in; only events are asynchronous.
//
// How it works
// - Each event input is qualified as a rising, falling or either edge by its own select.
// - A trigger fires a pulse, a run of converter commands, or both, to the outside.
// - In triggered mode the OR of the selected events reloads and restarts the counter.
// - In triggered mode eight comparators each fire their trigger at a programmed delay.
// - In sequential mode one comparator fires the trigger of whichever event came; any event reloads, event 0 starts the command period.
// - Every trigger owns a list of commands and a mask of pulses to issue when it fires.
// - A command carries channel, converter, single or dual sampling, and result FIFO.
// - Four result FIFOs exist, two of sixteen entries and two of four.
// - Both results of a dual conversion go to the one FIFO the command names.
// - At most twenty-four commands go out between two period starts (reload events, event 0 in sequential mode); excess is dropped and flagged.
// - The next command leaves only after the converter reports completion of the last one.
// - A one-cycle interrupt request is raised whenever any trigger fires.
`timescale 1ns/1ps
`default_nettype none
module ets_scheduler
   import ets_pkg::*;
#(
   parameter int NUM_EVENTS = ETS_NUM_EVENTS,
   parameter int NUM_TRIG = ETS_NUM_TRIG,
   parameter int MAX_CMDS = ETS_MAX_CMDS
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [NUM_EVENTS-1:0] event_in,
   input wire logic [NUM_EVENTS-1:0][1:0] edge_sel_in,
   input wire logic mode_seq_in,
   input wire logic [NUM_EVENTS-1:0] reload_mask_in,
   input wire logic [NUM_TRIG-1:0] trig_enable_in,
   input wire ets_trig_cfg_t [NUM_TRIG-1:0] trig_cfg_in,
   input wire logic cmd_wr_en_in,
   input wire logic [ETS_CMD_IDX_W-1:0] cmd_wr_addr_in,
   input wire ets_cmd_t cmd_wr_data_in,
   output ets_cmd_t adc_cmd_out,
   output logic [ETS_NUM_ADC-1:0] adc_cmd_valid_out,
   input wire logic [ETS_NUM_ADC-1:0] adc_done_in,
   input wire logic [ETS_NUM_ADC-1:0] adc_result_valid_in,
   input wire logic [ETS_NUM_ADC-1:0][ETS_RES_W-1:0] adc_result_in,
   input wire logic [ETS_NUM_FIFO-1:0] fifo_rd_in,
   output ets_result_t [ETS_NUM_FIFO-1:0] fifo_data_out,
   output logic [ETS_NUM_FIFO-1:0] fifo_valid_out,
   output logic [ETS_NUM_FIFO-1:0] fifo_empty_out,
   output logic [NUM_TRIG-1:0] trig_out,
   output logic [ETS_NUM_PULSE-1:0] pulse_out,
   output logic trig_irq_out,
   output logic overrun_out,
   output logic budget_err_out
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Index of the lowest set bit
   function automatic logic [2:0] lowest_index(input logic [7:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Depth of FIFO number i
   function automatic int fifo_depth(input int i);
      return (i < ETS_DEEP_FIFOS) ? ETS_DEEP_DEPTH : ETS_SHALLOW_DEPTH;
   endfunction

   // Converters that a command starts
   function automatic logic [ETS_NUM_ADC-1:0] adc_mask(input ets_cmd_t c);
      return c.dual ? '1 : ETS_NUM_ADC'(1 << c.adc_sel);
   endfunction

   localparam logic [ETS_CMD_IDX_W-1:0] BUDGET_MAX = ETS_CMD_IDX_W'(MAX_CMDS);

   logic [NUM_EVENTS-1:0] ev_hit;
   logic reload;
   logic period_start;
   logic [ETS_CNT_W-1:0] counter_reg;
   logic running_reg;
   logic [2:0] seq_idx_reg;
   logic [NUM_TRIG-1:0] fire;
   logic [NUM_TRIG-1:0] pending_reg;
   logic [NUM_TRIG-1:0] take;
   ets_state_t state_reg;
   logic [ETS_CMD_IDX_W-1:0] cmd_ptr_reg;
   logic [ETS_CMD_IDX_W-1:0] cmd_left_reg;
   logic [ETS_CMD_IDX_W-1:0] budget_reg;
   logic [ETS_NUM_ADC-1:0] wait_mask_reg;
   logic [ETS_NUM_ADC-1:0] done_seen_reg;
   logic [ETS_NUM_ADC-1:0] done_all;
   ets_cmd_t cmd_mem [0:MAX_CMDS-1];
   ets_cmd_t cur_cmd_reg;
   logic [ETS_NUM_ADC-1:0] hold_valid_reg;
   ets_result_t [ETS_NUM_ADC-1:0] hold_reg;
   logic [ETS_NUM_ADC-1:0] hold_take;
   logic [ETS_NUM_FIFO-1:0] fifo_ready;
   ets_result_t wr_entry;
   logic wr_any;
   logic [ETS_NUM_ADC-1:0][1:0] hold_fifo_reg;
   logic [1:0] wr_fifo;
   logic [2:0] pick;

   // ------------------------------------------------------------
   // Event capture
   // ------------------------------------------------------------
   ets_edge_detect #(
      .N(NUM_EVENTS)
   ) u_edge (
      .clock_in(clock_in),
      .reset_n_in(reset_n_in),
      .event_in(event_in),
      .edge_sel_in(edge_sel_in),
      .hit_out(ev_hit)
   );

   // Restart sources per mode
   assign reload = mode_seq_in ? (|ev_hit) : (|(ev_hit & reload_mask_in));
   assign period_start = mode_seq_in ? ev_hit[0] : reload;

   // ------------------------------------------------------------
   // Scheduling counter
   // ------------------------------------------------------------
   // Counter restarts at zero on reload; it stops after full scale (wrapping to zero) or after a fire in sequential mode
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         counter_reg <= '0;
         running_reg <= 1'b0;
         seq_idx_reg <= 3'h0;
      end else if (reload) begin
         counter_reg <= '0;
         running_reg <= 1'b1;
         seq_idx_reg <= lowest_index(8'(ev_hit));
      end else if (running_reg) begin
         counter_reg <= counter_reg + 1'b1;
         if (&counter_reg || (mode_seq_in && |fire)) begin
            running_reg <= 1'b0;
         end
      end
   end

   // Comparators
   always_comb begin
      fire = '0;
      for (int i = 0; i < NUM_TRIG; i++) begin
         fire[i] = running_reg && trig_enable_in[i] && (!mode_seq_in || seq_idx_reg == 3'(i))
            && (counter_reg == trig_cfg_in[i].delay);
      end
   end

   // ------------------------------------------------------------
   // Trigger outputs
   // ------------------------------------------------------------
   // Trigger strobes, pulse lines and interrupt request
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         trig_out <= '0;
         pulse_out <= '0;
         trig_irq_out <= 1'b0;
         overrun_out <= 1'b0;
      end else begin
         trig_out <= fire;
         trig_irq_out <= |fire;
         overrun_out <= |(fire & pending_reg & ~take);
         pulse_out <= pulse_or(fire);
      end
   end

   // OR of pulse masks of fired triggers
   function automatic logic [ETS_NUM_PULSE-1:0] pulse_or(input logic [NUM_TRIG-1:0] f);
      logic [ETS_NUM_PULSE-1:0] p;
      p = '0;
      for (int i = 0; i < NUM_TRIG; i++) begin
         if (f[i]) begin
            p = p | trig_cfg_in[i].pulse_mask;
         end
      end
      return p;
   endfunction

   // Pending command lists; a new fire wins over the take
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pending_reg <= '0;
      end else begin
         pending_reg <= (pending_reg & ~take) | fire;
      end
   end

   // ------------------------------------------------------------
   // Command list storage
   // ------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (cmd_wr_en_in && cmd_wr_addr_in < BUDGET_MAX) begin
         cmd_mem[cmd_wr_addr_in] <= cmd_wr_data_in;
      end
   end

   // ------------------------------------------------------------
   // Command sequencer
   // ------------------------------------------------------------
   assign pick = lowest_index(8'(pending_reg));
   assign take = (state_reg == ETS_ST_IDLE && |pending_reg) ? NUM_TRIG'(1 << pick) : '0;
   assign done_all = done_seen_reg | adc_done_in;

   // Issue one command, then wait for the converter
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= ETS_ST_IDLE;
         cmd_ptr_reg <= '0;
         cmd_left_reg <= '0;
         wait_mask_reg <= '0;
         done_seen_reg <= '0;
         cur_cmd_reg <= '0;
         adc_cmd_out <= '0;
         adc_cmd_valid_out <= '0;
         budget_err_out <= 1'b0;
      end else begin
         adc_cmd_valid_out <= '0;
         budget_err_out <= 1'b0;
         case (state_reg)
            ETS_ST_IDLE: begin
               if (|pending_reg) begin
                  cmd_ptr_reg <= trig_cfg_in[pick].first_cmd;
                  cmd_left_reg <= trig_cfg_in[pick].num_cmd;
                  if (trig_cfg_in[pick].num_cmd != '0) begin
                     state_reg <= ETS_ST_SEND;
                  end
               end
            end
            ETS_ST_SEND: begin
               if (budget_reg >= BUDGET_MAX || cmd_ptr_reg >= BUDGET_MAX) begin
                  budget_err_out <= 1'b1;
                  state_reg <= ETS_ST_IDLE;
               end else begin
                  adc_cmd_out <= cmd_mem[cmd_ptr_reg];
                  cur_cmd_reg <= cmd_mem[cmd_ptr_reg];
                  adc_cmd_valid_out <= adc_mask(cmd_mem[cmd_ptr_reg]);
                  wait_mask_reg <= adc_mask(cmd_mem[cmd_ptr_reg]);
                  done_seen_reg <= '0;
                  state_reg <= ETS_ST_WAIT;
               end
            end
            ETS_ST_WAIT: begin
               done_seen_reg <= done_all & wait_mask_reg;
               if ((done_all & wait_mask_reg) == wait_mask_reg) begin
                  cmd_ptr_reg <= cmd_ptr_reg + 1'b1;
                  cmd_left_reg <= cmd_left_reg - 1'b1;
                  state_reg <= (cmd_left_reg == ETS_CMD_IDX_W'(1)) ? ETS_ST_IDLE : ETS_ST_SEND;
               end
            end
            default: begin
               state_reg <= ETS_ST_IDLE;
            end
         endcase
      end
   end

   // Commands issued in the current control period
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         budget_reg <= '0;
      end else if (period_start) begin
         budget_reg <= '0;
      end else if (state_reg == ETS_ST_SEND && budget_reg < BUDGET_MAX
            && cmd_ptr_reg < BUDGET_MAX) begin
         budget_reg <= budget_reg + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Result routing
   // ------------------------------------------------------------
   // Converter 0 first; both results go to the command's FIFO
   always_comb begin
      hold_take = '0;
      wr_entry = hold_reg[0];
      wr_fifo = hold_fifo_reg[0];
      if (hold_valid_reg[0]) begin
         hold_take[0] = fifo_ready[wr_fifo];
      end else if (hold_valid_reg[1]) begin
         wr_entry = hold_reg[1];
         wr_fifo = hold_fifo_reg[1];
         hold_take[1] = fifo_ready[wr_fifo];
      end
   end
   assign wr_any = |hold_valid_reg;

   // Holding stage per converter
   genvar a;
   for (a = 0; a < ETS_NUM_ADC; a++) begin : g_hold
      always_ff @(posedge clock_in or negedge reset_n_in) begin
         if (!reset_n_in) begin
            hold_valid_reg[a] <= 1'b0;
            hold_reg[a] <= '0;
            hold_fifo_reg[a] <= '0;
         end else if (adc_result_valid_in[a]) begin
            hold_valid_reg[a] <= 1'b1;
            hold_fifo_reg[a] <= cur_cmd_reg.fifo_sel;
            hold_reg[a] <= '{adc_id: 1'(a), chan: cur_cmd_reg.chan, data: adc_result_in[a]};
         end else if (hold_take[a]) begin
            hold_valid_reg[a] <= 1'b0;
         end
      end
   end

   // Four result FIFOs of two depths
   genvar f;
   for (f = 0; f < ETS_NUM_FIFO; f++) begin : g_fifo
      ets_result_fifo #(
         .WIDTH($bits(ets_result_t)),
         .DEPTH(fifo_depth(f))
      ) u_fifo (
         .clock_in(clock_in),
         .reset_n_in(reset_n_in),
         .wr_valid_in(wr_any && wr_fifo == 2'(f)),
         .wr_data_in(wr_entry),
         .wr_ready_out(fifo_ready[f]),
         .rd_in(fifo_rd_in[f]),
         .rd_data_out(fifo_data_out[f]),
         .rd_valid_out(fifo_valid_out[f]),
         .empty_out(fifo_empty_out[f])
      );
   end
endmodule
`default_nettype wire

// >>> bench/ets_scheduler_properties.sv
// Concurrent checks on the scheduler outputs against their causes.
// Assumes it is bound into ets_scheduler and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ets_scheduler_checker
   import ets_pkg::*;
#(
   parameter int NUM_TRIG = ETS_NUM_TRIG
) (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [NUM_TRIG-1:0] trig_enable_in,
   input wire ets_cmd_t adc_cmd_out,
   input wire logic [ETS_NUM_ADC-1:0] adc_cmd_valid_out,
   input wire logic [ETS_NUM_ADC-1:0] adc_done_in,
   input wire logic [ETS_NUM_FIFO-1:0] fifo_rd_in,
   input wire logic [ETS_NUM_FIFO-1:0] fifo_valid_out,
   input wire logic [ETS_NUM_FIFO-1:0] fifo_empty_out,
   input wire logic [NUM_TRIG-1:0] trig_out,
   input wire logic [ETS_NUM_PULSE-1:0] pulse_out,
   input wire logic trig_irq_out,
   input wire logic overrun_out,
   input wire logic budget_err_out
);
   logic [ETS_NUM_ADC-1:0] wait_reg;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // Converters still owing a completion
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wait_reg <= '0;
      end else begin
         wait_reg <= (wait_reg & ~adc_done_in) | adc_cmd_valid_out;
      end
   end
   sequence s_issue;
      |adc_cmd_valid_out;
   endsequence
   // Output relations
   a_irq_tracks_trig: assert property (trig_irq_out == (|trig_out))
      else $error("irq does not match trigger");
   a_pulse_needs_trig: assert property (|pulse_out |-> |trig_out)
      else $error("pulse without trigger");
   a_trig_only_enabled: assert property ((trig_out & ~$past(trig_enable_in)) == 0)
      else $error("disabled trigger fired");
   a_overrun_has_trig: assert property (overrun_out |-> |trig_out)
      else $error("overrun without trigger");
   a_cmd_one_cycle: assert property (s_issue |=> !(|adc_cmd_valid_out))
      else $error("command strobe too long");
   a_dual_both_adc: assert property (s_issue ##0 adc_cmd_out.dual |-> adc_cmd_valid_out == 2'h3)
      else $error("dual command not sent to both");
   a_single_one_adc: assert property (s_issue ##0 !adc_cmd_out.dual |->
      adc_cmd_valid_out == (adc_cmd_out.adc_sel ? 2'h2 : 2'h1))
      else $error("single command to wrong converter");
   a_cmd_waits_done: assert property (s_issue |-> wait_reg == 0)
      else $error("command issued before completion");
   a_pop_gives_data: assert property (|fifo_valid_out |->
      (fifo_valid_out & ~$past(fifo_rd_in & ~fifo_empty_out)) == 0)
      else $error("fifo data without pop");
   c_budget_hit: cover property (budget_err_out);
endmodule
bind ets_scheduler ets_scheduler_checker #(.NUM_TRIG(NUM_TRIG)) u_chk (
   .clock_in, .reset_n_in, .trig_enable_in, .adc_cmd_out, .adc_cmd_valid_out, .adc_done_in,
   .fifo_rd_in, .fifo_valid_out, .fifo_empty_out, .trig_out, .pulse_out, .trig_irq_out,
   .overrun_out, .budget_err_out);
`default_nettype wire

// >>> bench/ets_adc_model.sv
// Behavioural pair of converters answering scheduler commands.
// Assumes the same clock as the scheduler; delay_in sets conversion time.
`timescale 1ns/1ps
`default_nettype none
module ets_adc_model
   import ets_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire ets_cmd_t adc_cmd_in,
   input wire logic [ETS_NUM_ADC-1:0] adc_cmd_valid_in,
   input wire logic [3:0] delay_in,
   output logic [ETS_NUM_ADC-1:0] adc_done_out,
   output logic [ETS_NUM_ADC-1:0] adc_result_valid_out,
   output logic [ETS_NUM_ADC-1:0][ETS_RES_W-1:0] adc_result_out
);
   logic [ETS_NUM_ADC-1:0][4:0] busy_reg;
   logic [ETS_NUM_ADC-1:0][ETS_CHAN_W-1:0] chan_reg;
   // Conversion timer; result and completion leave together
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_reg <= '0;
         chan_reg <= '0;
         adc_done_out <= '0;
         adc_result_valid_out <= '0;
         adc_result_out <= '0;
      end else begin
         for (int k = 0; k < ETS_NUM_ADC; k++) begin
            adc_done_out[k] <= 1'b0;
            adc_result_valid_out[k] <= 1'b0;
            adc_result_out[k] <= ~adc_result_out[k]; // Idle data keeps moving
            if (adc_cmd_valid_in[k]) begin
               busy_reg[k] <= {1'b0, delay_in} + 5'h01;
               chan_reg[k] <= adc_cmd_in.chan;
            end else if (busy_reg[k] == 5'h01) begin
               busy_reg[k] <= 5'h00;
               adc_done_out[k] <= 1'b1;
               adc_result_valid_out[k] <= 1'b1;
               adc_result_out[k] <= {k[0], 6'h15, chan_reg[k]};
            end else if (busy_reg[k] != 5'h00) begin
               busy_reg[k] <= busy_reg[k] - 5'h01;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/tb_trigger_scheduler_adc_sequencer.sv
// Self-checking bench: random schedules, edge modes, sequencing, budget.
// Assumes ets_scheduler and the converter model share clock_in.
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_scheduler_adc_sequencer;
   import ets_pkg::*;
   logic clock_in = 1'b0, reset_n_in = 1'b0, mode_seq = 1'b0, cmd_wr_en = 1'b0;
   logic [7:0] event_in = '0, reload_mask = '0, trig_enable = '0;
   logic [7:0][1:0] edge_sel = '0;
   ets_trig_cfg_t [7:0] cfg = '0;
   logic [4:0] cmd_wr_addr = '0;
   ets_cmd_t cmd_wr_data = '0, cmd_out, c0, c1;
   logic [1:0] cmd_valid, done, res_valid;
   logic [1:0][11:0] res;
   logic [3:0] fifo_rd = '0, delay = '0, fifo_valid, fifo_empty, pulse, m0, m1;
   ets_result_t [3:0] fifo_data;
   logic [7:0] trig;
   logic irq, overrun, budget_err;
   logic [15:0] d0, d1;
   int errors = 0, check_count = 0, cyc = 0, cmd_cnt = 0, budget_cnt = 0, base, tot, k;
   int trig_cnt[8], trig_cyc[8];
   logic [3:0] pulse_at[8];
   ets_scheduler u_dut (.clock_in, .reset_n_in, .event_in,
      .edge_sel_in(edge_sel), .mode_seq_in(mode_seq), .reload_mask_in(reload_mask),
      .trig_enable_in(trig_enable), .trig_cfg_in(cfg), .cmd_wr_en_in(cmd_wr_en),
      .cmd_wr_addr_in(cmd_wr_addr), .cmd_wr_data_in(cmd_wr_data), .adc_cmd_out(cmd_out),
      .adc_cmd_valid_out(cmd_valid), .adc_done_in(done), .adc_result_valid_in(res_valid),
      .adc_result_in(res), .fifo_rd_in(fifo_rd), .fifo_data_out(fifo_data),
      .fifo_valid_out(fifo_valid), .fifo_empty_out(fifo_empty), .trig_out(trig),
      .pulse_out(pulse), .trig_irq_out(irq), .overrun_out(overrun),
      .budget_err_out(budget_err));
   ets_adc_model u_adc (.clock_in, .reset_n_in, .adc_cmd_in(cmd_out),
      .adc_cmd_valid_in(cmd_valid), .delay_in(delay), .adc_done_out(done),
      .adc_result_valid_out(res_valid), .adc_result_out(res));
   // 40 MHz clock
   initial begin
      forever #12.5 clock_in = ~clock_in;
   end
   // Output monitor
   always @(posedge clock_in) begin
      cyc++;
      if (cmd_valid !== 2'h0) cmd_cnt++;
      if (budget_err === 1'b1) budget_cnt++;
      for (int i = 0; i < 8; i++) begin
         if (trig[i] === 1'b1) begin
            trig_cnt[i]++;
            trig_cyc[i] = cyc;
            pulse_at[i] = pulse;
         end
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic nwait(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic wr_cmd(input logic [4:0] a, input ets_cmd_t c);
      @(negedge clock_in);
      cmd_wr_en = 1'b1;
      cmd_wr_addr = a;
      cmd_wr_data = c;
      @(negedge clock_in);
      cmd_wr_en = 1'b0;
   endtask
   function automatic ets_result_t exp_res(input logic id, input logic [4:0] ch);
      return '{id, ch, {id, 6'h15, ch}};
   endfunction
   task automatic pop_chk(input int f, input ets_result_t e);
      @(negedge clock_in);
      fifo_rd[f] = 1'b1;
      @(negedge clock_in);
      fifo_rd[f] = 1'b0;
      chk(fifo_valid[f], 1'b1);
      chk(fifo_data[f], e);
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #250000;
      errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      void'($urandom(84));
      nwait(16);
      reset_n_in = 1'b1;
      nwait(2);
      chk(fifo_empty, 4'hf);
      chk(trig, 8'h00);
      // Two scheduled triggers, single then dual command
      c0 = '{2'h2, 1'b0, 1'b1, 5'($urandom)};
      c1 = '{2'h0, 1'b1, 1'b0, 5'($urandom)};
      wr_cmd(5'h00, c0);
      wr_cmd(5'h01, c1);
      d0 = 16'($urandom_range(2, 20));
      d1 = d0 + 16'($urandom_range(3, 20));
      m0 = 4'($urandom_range(1, 15));
      m1 = 4'($urandom_range(1, 15));
      delay = 4'($urandom);
      cfg[0] = '{d0, 5'h00, 5'h01, m0};
      cfg[1] = '{d1, 5'h01, 5'h01, m1};
      edge_sel[0] = ETS_EDGE_RISE;
      reload_mask = 8'h01;
      trig_enable = 8'h03;
      event_in[0] = 1'b1;
      nwait(120);
      chk(trig_cnt[0], 1);
      chk(trig_cyc[1] - trig_cyc[0], d1 - d0);
      chk(pulse_at[0], m0);
      chk(pulse_at[1], m1);
      pop_chk(2, exp_res(1'b1, c0.chan));
      pop_chk(0, exp_res(1'b0, c1.chan));
      pop_chk(0, exp_res(1'b1, c1.chan));
      nwait(3);
      chk(fifo_empty, 4'hf);
      // Edge selection and reload mask table
      trig_enable = 8'h01;
      cfg[0] = '{16'h0003, 5'h00, 5'h00, 4'h1};
      for (int t = 0; t < 5; t++) begin
         k = (t == 3) ? 1 : 0;
         event_in = '0;
         edge_sel = '0;
         nwait(30);
         edge_sel[k] = (t == 4) ? 2'h0 : (t == 3) ? 2'h3 : 2'(t + 1);
         base = trig_cnt[0];
         event_in[k] = 1'b1;
         nwait(30);
         event_in[k] = 1'b0;
         nwait(30);
         chk(trig_cnt[0] - base, (t == 2) ? 2 : (t > 2) ? 0 : 1);
      end
      // Sequential mode: event k fires trigger k once
      mode_seq = 1'b1;
      edge_sel = 16'h5555;
      k = $urandom_range(1, 7);
      trig_enable = 8'h01 << k;
      cfg[k] = '{16'($urandom_range(2, 30)), 5'h00, 5'h00, 4'h0};
      nwait(10);
      base = trig_cnt[k];
      tot = trig_cnt.sum();
      event_in[k] = 1'b1;
      nwait(60);
      chk(trig_cnt[k] - base, 1);
      chk(trig_cnt.sum() - tot, 1);
      // Command budget over one period
      event_in = '0;
      mode_seq = 1'b0;
      edge_sel = '0;
      edge_sel[0] = ETS_EDGE_RISE;
      trig_enable = 8'h03;
      cfg[0] = '{16'h0002, 5'h00, 5'd20, 4'h0};
      cfg[1] = '{16'h0004, 5'h00, 5'd8, 4'h0};
      for (int a = 0; a < 24; a++) wr_cmd(5'(a), ets_cmd_t'($urandom));
      fifo_rd = 4'hf;
      delay = 4'($urandom_range(0, 3));
      base = cmd_cnt;
      tot = budget_cnt;
      event_in[0] = 1'b1;
      for (int i = 0; i < 3000 && cmd_cnt - base < 24; i++) @(negedge clock_in);
      nwait(200);
      chk(cmd_cnt - base, 24);
      chk(budget_cnt > tot, 1);
      wrap_up();
   end
endmodule
`default_nettype wire
